// ==== rtl/zdc_regs.sv ====
// zero delay control and pll status register pair
module zdc_regs
  import zdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register access from the serial control port
  input wire logic [ZDC_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ZDC_DW-1:0] reg_wdata,
  output logic [ZDC_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  // synthesizer state
  input wire logic vco_cal_done,
  input wire logic holdover_active,
  input wire logic reference_input_two_sel,
  input wire logic vco_above_thresh,
  input wire logic ref_two_above_thresh,
  input wire logic ref_one_above_thresh,
  input wire logic pll_locked,
  input wire logic stat_update_hold,
  // channel dividers and zero delay path
  input wire logic [ZDC_NUM_DIV-1:0] chan_div_out,
  output logic ext_fb_out,
  output logic zd_int_on,
  output logic zd_ext_on
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic zd_en;
    logic zd_ext;
    logic [ZDC_FB_SEL_W-1:0] fb_sel;
    logic [ZDC_DW-1:0] rdata;
    logic rvalid;
  } zdc_regs_st_t;

  zdc_regs_st_t st_q;
  zdc_regs_st_t st_d;
  logic [ZDC_ST_W-1:0] stat_live;
  logic [ZDC_ST_W-1:0] stat_snap;
  logic hit_ctrl;
  logic hit_stat;
  logic [ZDC_DW-1:0] ctrl_view;

  assign hit_ctrl = (reg_addr == ZDC_ZD_CTRL_ADDR);
  assign hit_stat = (reg_addr == ZDC_PLL_STAT_ADDR);

  // ------------------------------------------------------------
  // live status assembly
  // ------------------------------------------------------------
  always_comb begin
    stat_live = ZDC_PLL_STAT_RST;
    stat_live[ZDC_ST_CAL_DONE_BIT] = vco_cal_done;
    stat_live[ZDC_ST_HOLDOVER_BIT] = holdover_active;
    stat_live[ZDC_ST_REF_TWO_SEL_BIT] = reference_input_two_sel;
    stat_live[ZDC_ST_VCO_HI_BIT] = vco_above_thresh;
    stat_live[ZDC_ST_REF_TWO_HI_BIT] = ref_two_above_thresh;
    stat_live[ZDC_ST_REF_ONE_HI_BIT] = ref_one_above_thresh;
    stat_live[ZDC_ST_LOCK_BIT] = pll_locked;
  end

  zdc_stat_snap u_stat (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .stat_live(stat_live),
    .stat_hold(stat_update_hold),
    .stat_snap(stat_snap)
  );

  // ------------------------------------------------------------
  // control readback image
  // ------------------------------------------------------------
  always_comb begin
    ctrl_view = ZDC_ZD_CTRL_RST;
    ctrl_view[ZDC_ZD_EN_BIT] = st_q.zd_en;
    ctrl_view[ZDC_ZD_EXT_BIT] = st_q.zd_ext;
    ctrl_view[ZDC_FB_SEL_LSB +: ZDC_FB_SEL_W] = st_q.fb_sel;
  end

  // ------------------------------------------------------------
  // register access
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    if (reg_wr && hit_ctrl) begin
      st_d.zd_en = reg_wdata[ZDC_ZD_EN_BIT];
      st_d.zd_ext = reg_wdata[ZDC_ZD_EXT_BIT];
      st_d.fb_sel = reg_wdata[ZDC_FB_SEL_LSB +: ZDC_FB_SEL_W];
    end
    // a write to the status address falls through untouched
    if (reg_rd) begin
      st_d.rvalid = 1'b1;
      if (hit_ctrl) begin
        st_d.rdata = ctrl_view;
      end else if (hit_stat) begin
        st_d.rdata = {1'b0, stat_snap};
      end else begin
        st_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{zd_en: ZDC_ZD_CTRL_RST[ZDC_ZD_EN_BIT],
                zd_ext: ZDC_ZD_CTRL_RST[ZDC_ZD_EXT_BIT],
                fb_sel: ZDC_FB_DIV0,
                rdata: 8'h00,
                rvalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;

  // ------------------------------------------------------------
  // feedback path
  // ------------------------------------------------------------
  zdc_fb_mux u_fb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .zd_en(st_q.zd_en),
    .zd_ext(st_q.zd_ext),
    .fb_sel(st_q.fb_sel),
    .chan_div_out(chan_div_out),
    .ext_fb_out(ext_fb_out),
    .zd_int_on(zd_int_on),
    .zd_ext_on(zd_ext_on)
  );

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_fb_div_three: assert property (
    st_q.zd_en && st_q.zd_ext && st_q.fb_sel == ZDC_FB_DIV3
    |=> ext_fb_out == $past(chan_div_out[3]))
    else $error("divider 3 not routed for selector 11");

  a_fb_div_low: assert property (
    st_q.zd_en && st_q.zd_ext && st_q.fb_sel != ZDC_FB_DIV3
    |=> ext_fb_out == $past(chan_div_out[st_q.fb_sel]))
    else $error("wrong divider routed for selector");

  a_sel_reset_zero: assert property (
    $rose(rst_n) |-> st_q.fb_sel == ZDC_FB_DIV0 && !st_q.zd_ext)
    else $error("selector not at divider 0 after reset");

  a_mode_internal: assert property (
    reg_wr && hit_ctrl && reg_wdata[ZDC_ZD_EN_BIT] && !reg_wdata[ZDC_ZD_EXT_BIT]
    |=> ##1 zd_int_on && !zd_ext_on)
    else $error("internal zero delay mode not entered");

  a_mode_external: assert property (
    reg_wr && hit_ctrl && reg_wdata[ZDC_ZD_EN_BIT] && reg_wdata[ZDC_ZD_EXT_BIT]
    |=> ##1 zd_ext_on && !zd_int_on)
    else $error("external zero delay mode not entered");

  a_enable_off: assert property (
    !st_q.zd_en |=> !zd_int_on && !zd_ext_on)
    else $error("zero delay active while disabled");

  a_disabled_inert: assert property (
    !st_q.zd_en [*2] |=> ext_fb_out == 1'b0)
    else $error("feedback driven while disabled");

  a_stat_readback: assert property (
    reg_rd && hit_stat |=> reg_rvalid && reg_rdata == {1'b0, $past(stat_snap)})
    else $error("status read returned wrong contents");

  a_stat_lock_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_LOCK_BIT] == $past(pll_locked, 2))
    else $error("lock bit does not follow lock detect");

  a_stat_cal_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_CAL_DONE_BIT] == $past(vco_cal_done, 2))
    else $error("calibration bit does not follow calibration state");

  a_stat_ro_write: assert property (
    reg_wr && hit_stat |=> $stable(ctrl_view))
    else $error("status write disturbed control");

  a_stat_held_read: assert property (
    stat_update_hold [*3] ##0 reg_rd && hit_stat
    |=> reg_rdata == {1'b0, $past(stat_snap, 2)})
    else $error("held status changed under hold");

  a_unmapped_zero: assert property (
    reg_rd && !hit_ctrl && !hit_stat |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_hold_bit_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_HOLDOVER_BIT] == $past(holdover_active, 2))
    else $error("holdover bit does not follow holdover state");

  a_ref_sel_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_REF_TWO_SEL_BIT] == $past(reference_input_two_sel, 2))
    else $error("reference select bit does not follow selection");

  a_vco_hi_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_VCO_HI_BIT] == $past(vco_above_thresh, 2))
    else $error("vco threshold bit does not follow monitor");

  a_ref_two_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_REF_TWO_HI_BIT] == $past(ref_two_above_thresh, 2))
    else $error("ref two threshold bit does not follow monitor");

  a_ref_one_path: assert property (
    !stat_update_hold ##1 reg_rd && hit_stat
    |=> reg_rdata[ZDC_ST_REF_ONE_HI_BIT] == $past(ref_one_above_thresh, 2))
    else $error("ref one threshold bit does not follow monitor");

  a_rvalid_answer: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");

  a_rvalid_quiet: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");

  a_rdata_keep: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  a_en_write_lands: assert property (
    reg_wr && hit_ctrl |=> st_q.zd_en == $past(reg_wdata[ZDC_ZD_EN_BIT]))
    else $error("enable bit write lost");

  a_sel_write_lands: assert property (
    reg_wr && hit_ctrl
    |=> st_q.fb_sel == $past(reg_wdata[ZDC_FB_SEL_LSB +: ZDC_FB_SEL_W]))
    else $error("selector write lost");

  a_ctrl_keep: assert property (
    !(reg_wr && hit_ctrl)
    |=> $stable(st_q.zd_en) && $stable(st_q.zd_ext) && $stable(st_q.fb_sel))
    else $error("control changed without a control write");

  a_int_no_fb: assert property (
    zd_int_on |-> !ext_fb_out)
    else $error("feedback driven in internal mode");

  a_modes_apart: assert property (
    !(zd_int_on && zd_ext_on))
    else $error("both zero delay modes active");

  a_ext_sel_ok: assert property (
    zd_ext_on |-> $past(st_q.zd_en && st_q.zd_ext))
    else $error("external mode without enable and mode bits");

  a_int_sel_ok: assert property (
    zd_int_on |-> $past(st_q.zd_en && !st_q.zd_ext))
    else $error("internal mode without enable");

  a_ctrl_old_read: assert property (
    reg_rd && hit_ctrl |=> reg_rdata == $past(ctrl_view))
    else $error("control read returned wrong contents");

  a_ctrl_spare_zero: assert property (
    reg_rd && hit_ctrl |=> !reg_rdata[0] && reg_rdata[7:5] == 3'h0)
    else $error("spare control bits not zero");

  c_ext_div3: cover property (
    st_q.zd_en && st_q.zd_ext && st_q.fb_sel == ZDC_FB_DIV3 ##1 ext_fb_out);
  c_int_mode: cover property (zd_int_on ##1 zd_int_on);
  c_held_read: cover property (stat_update_hold [*2] ##0 reg_rd && hit_stat);
  c_ctrl_read: cover property (reg_wr && hit_ctrl ##1 reg_rd && hit_ctrl);
  c_stat_write: cover property (reg_wr && hit_stat);

endmodule

// ==== rtl/zdc_pkg.sv ====
// constants for the zero delay control and pll status register pair
package zdc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ZDC_AW = 10;
  localparam int ZDC_DW = 8;
  localparam logic [ZDC_AW-1:0] ZDC_ZD_CTRL_ADDR = 10'h01e;
  localparam logic [ZDC_AW-1:0] ZDC_PLL_STAT_ADDR = 10'h01f;

  // ------------------------------------------------------------
  // zero delay control fields
  // ------------------------------------------------------------
  localparam int ZDC_ZD_EN_BIT = 1;
  localparam int ZDC_ZD_EXT_BIT = 2;
  localparam int ZDC_FB_SEL_LSB = 3;
  localparam int ZDC_FB_SEL_W = 2;
  localparam logic [ZDC_DW-1:0] ZDC_ZD_CTRL_RST = 8'h00;

  // ------------------------------------------------------------
  // feedback divider selector codes
  // ------------------------------------------------------------
  localparam logic [1:0] ZDC_FB_DIV0 = 2'h0;
  localparam logic [1:0] ZDC_FB_DIV1 = 2'h1;
  localparam logic [1:0] ZDC_FB_DIV2 = 2'h2;
  localparam logic [1:0] ZDC_FB_DIV3 = 2'h3;
  localparam int ZDC_NUM_DIV = 4;

  // ------------------------------------------------------------
  // pll status fields
  // ------------------------------------------------------------
  localparam int ZDC_ST_LOCK_BIT = 0;
  localparam int ZDC_ST_REF_ONE_HI_BIT = 1;
  localparam int ZDC_ST_REF_TWO_HI_BIT = 2;
  localparam int ZDC_ST_VCO_HI_BIT = 3;
  localparam int ZDC_ST_REF_TWO_SEL_BIT = 4;
  localparam int ZDC_ST_HOLDOVER_BIT = 5;
  localparam int ZDC_ST_CAL_DONE_BIT = 6;
  localparam int ZDC_ST_W = 7;
  localparam logic [ZDC_ST_W-1:0] ZDC_PLL_STAT_RST = 7'h00;

endpackage

// ==== rtl/zdc_stat_snap.sv ====
// status snapshot register with update hold
module zdc_stat_snap
  import zdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // live synthesizer state
  input wire logic [ZDC_ST_W-1:0] stat_live,
  input wire logic stat_hold,
  // held snapshot
  output logic [ZDC_ST_W-1:0] stat_snap
);

  typedef struct packed {
    logic [ZDC_ST_W-1:0] snap;
  } zdc_snap_st_t;

  zdc_snap_st_t st_q;
  zdc_snap_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (!stat_hold) begin
      st_d.snap = stat_live;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{snap: ZDC_PLL_STAT_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign stat_snap = st_q.snap;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_snap_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stat_hold [*2] |-> $stable(stat_snap))
    else $error("status changed while updates held");

  a_snap_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !stat_hold |=> stat_snap == $past(stat_live))
    else $error("status snapshot missed live state");

endmodule

// ==== rtl/zdc_fb_mux.sv ====
// zero delay feedback divider selection and mode decode
module zdc_fb_mux
  import zdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control fields
  input wire logic zd_en,
  input wire logic zd_ext,
  input wire logic [ZDC_FB_SEL_W-1:0] fb_sel,
  // channel divider outputs
  input wire logic [ZDC_NUM_DIV-1:0] chan_div_out,
  // feedback path
  output logic ext_fb_out,
  output logic zd_int_on,
  output logic zd_ext_on
);

  typedef struct packed {
    logic fb;
    logic int_on;
    logic ext_on;
  } zdc_fb_st_t;

  zdc_fb_st_t st_q;
  zdc_fb_st_t st_d;
  logic [ZDC_NUM_DIV-1:0] pick;

  // one-hot divider pick per channel
  genvar gi;
  generate
    for (gi = 0; gi < ZDC_NUM_DIV; gi++) begin : g_pick
      assign pick[gi] = (fb_sel == ZDC_FB_SEL_W'(gi)) & chan_div_out[gi];
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.fb = 1'b0;
    st_d.int_on = 1'b0;
    st_d.ext_on = 1'b0;
    if (zd_en) begin
      if (zd_ext) begin
        st_d.ext_on = 1'b1;
        st_d.fb = |pick;
      end else begin
        st_d.int_on = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{fb: 1'b0, int_on: 1'b0, ext_on: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign ext_fb_out = st_q.fb;
  assign zd_int_on = st_q.int_on;
  assign zd_ext_on = st_q.ext_on;

endmodule

// ==== sim/zero_delay_ctrl_pll_status_regs_tb.sv ====
// self-checking bench for the zero delay control and pll status register pair
module zero_delay_ctrl_pll_status_regs_tb
  import zdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys;
  logic rst_n;
  logic [ZDC_AW-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [ZDC_DW-1:0] reg_wdata;
  logic [ZDC_DW-1:0] reg_rdata;
  logic reg_rvalid;
  logic [ZDC_ST_W-1:0] live;
  logic stat_update_hold;
  logic [ZDC_NUM_DIV-1:0] chan_div_out;
  logic ext_fb_out;
  logic zd_int_on;
  logic zd_ext_on;
  int err_count;
  int checks;
  logic [7:0] v;

  zdc_regs dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .vco_cal_done(live[6]),
    .holdover_active(live[5]),
    .reference_input_two_sel(live[4]),
    .vco_above_thresh(live[3]),
    .ref_two_above_thresh(live[2]),
    .ref_one_above_thresh(live[1]),
    .pll_locked(live[0]),
    .stat_update_hold(stat_update_hold),
    .chan_div_out(chan_div_out),
    .ext_fb_out(ext_fb_out),
    .zd_int_on(zd_int_on),
    .zd_ext_on(zd_ext_on)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [ZDC_AW-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ZDC_AW-1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 8'h01, {7'h00, reg_rvalid});
    d = reg_rdata;
  endtask

  task automatic chk_modes(input logic i, input logic e, input logic f);
    chk("internal mode", {7'h00, i}, {7'h00, zd_int_on});
    chk("external mode", {7'h00, e}, {7'h00, zd_ext_on});
    chk("feedback out", {7'h00, f}, {7'h00, ext_fb_out});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    rd(ZDC_ZD_CTRL_ADDR, v);
    chk("control after reset", 8'h00, v);
    rd(ZDC_PLL_STAT_ADDR, v);
    chk("status after reset", 8'h00, v);
    chk_modes(1'b0, 1'b0, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_fb_select;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      chan_div_out <= 4'h1 << s;
      wr(ZDC_ZD_CTRL_ADDR, {3'b111, s[1:0], 3'b111});
      wait_cyc(2);
      chk_modes(1'b0, 1'b1, 1'b1);
      rd(ZDC_ZD_CTRL_ADDR, v);
      chk("control readback", {3'b000, s[1:0], 3'b110}, v);
      @(posedge clk_sys);
      chan_div_out <= ~(4'h1 << s);
      wait_cyc(2);
      chk_modes(1'b0, 1'b1, 1'b0);
    end
    $display("test feedback select done");
  endtask

  task automatic test_int_and_off;
    @(posedge clk_sys);
    chan_div_out <= 4'hf;
    wr(ZDC_ZD_CTRL_ADDR, 8'h1a);
    wait_cyc(2);
    chk_modes(1'b1, 1'b0, 1'b0);
    wr(ZDC_ZD_CTRL_ADDR, 8'h1c);
    wait_cyc(2);
    chk_modes(1'b0, 1'b0, 1'b0);
    rd(ZDC_ZD_CTRL_ADDR, v);
    chk("control disabled", 8'h1c, v);
    $display("test internal and disabled done");
  endtask

  task automatic test_status_bits;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      live <= 7'h01 << i;
      wait_cyc(2);
      rd(ZDC_PLL_STAT_ADDR, v);
      chk("status bit", {1'b0, 7'h01 << i}, v);
    end
    $display("test status bits done");
  endtask

  task automatic test_hold_and_ro;
    @(posedge clk_sys);
    live <= 7'h55;
    wait_cyc(2);
    @(posedge clk_sys);
    stat_update_hold <= 1'b1;
    live <= 7'h2a;
    wait_cyc(3);
    rd(ZDC_PLL_STAT_ADDR, v);
    chk("held status", 8'h55, v);
    @(posedge clk_sys);
    stat_update_hold <= 1'b0;
    wait_cyc(2);
    rd(ZDC_PLL_STAT_ADDR, v);
    chk("released status", 8'h2a, v);
    wr(ZDC_PLL_STAT_ADDR, 8'hd5);
    wait_cyc(2);
    rd(ZDC_PLL_STAT_ADDR, v);
    chk("status after write", 8'h2a, v);
    rd(ZDC_ZD_CTRL_ADDR, v);
    chk("control after status write", 8'h1c, v);
    rd(10'h01d, v);
    chk("unmapped read", 8'h00, v);
    $display("test hold and read only done");
  endtask

  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = '0;
    live = '0;
    stat_update_hold = 1'b0;
    chan_div_out = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_reset();
    test_fb_select();
    test_int_and_off();
    test_status_bits();
    test_hold_and_ro();
    tally_and_finish();
  end

  initial begin
    #(50 * 5000);
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule
